// ==== ptp_pkg.sv ====
// Constants and types for the programmable trigger pin block.
// Assumes a single 20 MHz AHB-Lite clock domain.
package ptp_pkg;

    // ==========================================================
    // Register byte offsets (decoded on haddr[7:0])
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CMD      = 8'h04;
    localparam logic [7:0] ADDR_PWM_PER  = 8'h08;
    localparam logic [7:0] ADDR_PWM_DUTY = 8'h0c;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;

    // ==========================================================
    // CTRL fields
    localparam int CTRL_INV_BIT    = 0;
    localparam int CTRL_MODE_LSB   = 1;
    localparam int CTRL_TGT_LSB    = 3;
    localparam int CTRL_VAL_BIT    = 5;
    localparam int CTRL_PWM_BIT    = 6;
    localparam int CTRL_SEQEXT_BIT = 7;
    localparam int CTRL_ARM_BIT    = 8;

    // CMD fields
    localparam int CMD_MANUAL_BIT  = 0;

    // STATUS fields
    localparam int STAT_PIN_BIT    = 0;
    localparam int STAT_LEVEL_BIT  = 1;
    localparam int STAT_BUSY_BIT   = 2;
    localparam int STAT_ARM_BIT    = 3;

    // ==========================================================
    // Reset values
    localparam logic [15:0] PWM_PER_RST  = 16'h03e8;
    localparam logic [15:0] PWM_DUTY_RST = 16'h01f4;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int TRIG_LOW_NS   = 30000;
    localparam int TRIG_LOW_CYC  = (TRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Modes and trigger targets
    typedef enum logic [1:0] {
        PTP_MODE_TRIG_OUT,
        PTP_MODE_TRIG_IN,
        PTP_MODE_LEVEL_IN,
        PTP_MODE_OUTPUT
    } ptp_mode_t;

    typedef enum logic [1:0] {
        PTP_TGT_MEAS,
        PTP_TGT_DLOG,
        PTP_TGT_SEQ,
        PTP_TGT_NONE
    } ptp_tgt_t;

endpackage : ptp_pkg

// ==== ptp_low_qual.sv ====
// Minimum-width qualifier for an active input level.
// Assumes the input is already synchronised to hclk.
`timescale 1ns/1ps
module ptp_low_qual #(
    parameter int MIN_CYC = ptp_pkg::TRIG_LOW_CYC
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic enable,
    input  wire logic active,
    output logic      fire
);
    localparam int CW = $clog2(MIN_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(MIN_CYC - 1);
    localparam logic [CW-1:0] CNT_DONE = CW'(MIN_CYC);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          fire;
    } ptp_qual_st_t;

    ptp_qual_st_t s_q;
    ptp_qual_st_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.fire = 1'b0;
        if (!enable || !active) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == CNT_LAST) begin
            // One start per accepted pulse, glitches never reach here
            s_d.cnt  = CNT_DONE;
            s_d.fire = 1'b1;
        end else if (s_q.cnt != CNT_DONE) begin
            s_d.cnt = s_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fire = s_q.fire;

endmodule : ptp_low_qual

// ==== ptp_trig_pin.sv ====
// Programmable trigger pin: trigger in/out, level in, level or PWM out.
// Assumes an AHB-Lite slave slot on hclk and an external pad with
// separate input, output and output enable.
//
// Behaviour
// - Polarity setting inverts every pin pulse/level
// - Default role is bidirectional trigger, out/in; the code resets to trigger out only, with the input qualifier off
// - Valid input pulse starts exactly one target; the code starts none for target none or an unarmed measurement
// - Measurement target starts measurement on pulse; the code starts it only while arm is set, then clears arm
// - Sequence responds only with external trigger source
// - Internal trigger emits low pulse, 30 us
// - Manual trigger starts sequence, also pulses pin
// - Output false drives high, inverted drives low
// - Output mode offers PWM, frequency and duty
// - Output true drives low, inverted drives high
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module ptp_trig_pin #(
    parameter int PWM_W = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        trig_event,
    input  wire logic        pin_i,
    output logic             pin_o,
    output logic             pin_oe,
    output logic             start_meas,
    output logic             start_dlog,
    output logic             start_seq
);

    // ==========================================================
    // State
    typedef struct packed {
        logic                sync1;
        logic                sync2;
        logic                inv;
        ptp_pkg::ptp_mode_t  mode;
        ptp_pkg::ptp_tgt_t   tgt;
        logic                out_val;
        logic                pwm_en;
        logic                seq_ext;
        logic                arm;
        logic [PWM_W-1:0]    pwm_per;
        logic [PWM_W-1:0]    pwm_duty;
        logic [PWM_W-1:0]    pwm_cnt;
        logic                busy;
        logic [15:0]         pulse_cnt;
        logic                wr_pend;
        logic [7:0]          wr_addr;
        logic [31:0]         hrdata;
        logic                hreadyout;
        logic                hresp;
        logic                pin_o;
        logic                pin_oe;
        logic                start_meas;
        logic                start_dlog;
        logic                start_seq;
    } ptp_st_t;

    localparam logic [15:0] PULSE_LAST = 16'(ptp_pkg::TRIG_LOW_CYC - 1);

    ptp_st_t s_q;
    ptp_st_t s_d;

    logic active_in;
    logic qual_fire;

    // Logical input level after polarity
    assign active_in = s_q.inv ? s_q.sync2 : ~s_q.sync2;

    // ==========================================================
    // Input pulse width qualifier
    ptp_low_qual #(
        .MIN_CYC (ptp_pkg::TRIG_LOW_CYC)
    ) u_qual (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (s_q.mode == ptp_pkg::PTP_MODE_TRIG_IN),
        .active  (active_in),
        .fire    (qual_fire)
    );

    // ==========================================================
    // Register read mux
    function automatic logic [31:0] read_reg(input logic [7:0] a, input ptp_st_t s, input logic lvl);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            ptp_pkg::ADDR_CTRL: begin
                r[ptp_pkg::CTRL_INV_BIT]          = s.inv;
                r[ptp_pkg::CTRL_MODE_LSB +: 2]    = s.mode;
                r[ptp_pkg::CTRL_TGT_LSB +: 2]     = s.tgt;
                r[ptp_pkg::CTRL_VAL_BIT]          = s.out_val;
                r[ptp_pkg::CTRL_PWM_BIT]          = s.pwm_en;
                r[ptp_pkg::CTRL_SEQEXT_BIT]       = s.seq_ext;
                r[ptp_pkg::CTRL_ARM_BIT]          = s.arm;
            end
            ptp_pkg::ADDR_PWM_PER: begin
                r[PWM_W-1:0] = s.pwm_per;
            end
            ptp_pkg::ADDR_PWM_DUTY: begin
                r[PWM_W-1:0] = s.pwm_duty;
            end
            ptp_pkg::ADDR_STATUS: begin
                r[ptp_pkg::STAT_PIN_BIT]   = s.sync2;
                r[ptp_pkg::STAT_LEVEL_BIT] = lvl;
                r[ptp_pkg::STAT_BUSY_BIT]  = s.busy;
                r[ptp_pkg::STAT_ARM_BIT]   = s.arm;
            end
            default: begin
                r = 32'h0000_0000;
            end
        endcase
        return r;
    endfunction : read_reg

    // ==========================================================
    // Next state
    always_comb begin
        logic manual;
        logic pwm_lvl;
        logic lout;
        manual  = 1'b0;
        pwm_lvl = 1'b0;
        lout    = 1'b0;

        s_d            = s_q;
        s_d.start_meas = 1'b0;
        s_d.start_dlog = 1'b0;
        s_d.start_seq  = 1'b0;
        s_d.hreadyout  = 1'b1;
        s_d.hresp      = 1'b0;

        // Synchroniser
        s_d.sync1 = pin_i;
        s_d.sync2 = s_q.sync1;

        // Input trigger dispatch, one target per pulse
        if (qual_fire) begin
            case (s_q.tgt)
                ptp_pkg::PTP_TGT_MEAS: begin
                    if (s_q.arm) begin
                        s_d.start_meas = 1'b1;
                        s_d.arm        = 1'b0;
                    end
                end
                ptp_pkg::PTP_TGT_DLOG: begin
                    s_d.start_dlog = 1'b1;
                end
                ptp_pkg::PTP_TGT_SEQ: begin
                    s_d.start_seq = s_q.seq_ext;
                end
                default: begin
                    s_d.start_seq = 1'b0;
                end
            endcase
        end

        // Bus data phase write
        if (s_q.wr_pend) begin
            case (s_q.wr_addr)
                ptp_pkg::ADDR_CTRL: begin
                    s_d.inv     = hwdata[ptp_pkg::CTRL_INV_BIT];
                    s_d.mode    = ptp_pkg::ptp_mode_t'(hwdata[ptp_pkg::CTRL_MODE_LSB +: 2]);
                    s_d.tgt     = ptp_pkg::ptp_tgt_t'(hwdata[ptp_pkg::CTRL_TGT_LSB +: 2]);
                    s_d.out_val = hwdata[ptp_pkg::CTRL_VAL_BIT];
                    s_d.pwm_en  = hwdata[ptp_pkg::CTRL_PWM_BIT];
                    s_d.seq_ext = hwdata[ptp_pkg::CTRL_SEQEXT_BIT];
                    s_d.arm     = hwdata[ptp_pkg::CTRL_ARM_BIT];
                end
                ptp_pkg::ADDR_CMD: begin
                    manual = hwdata[ptp_pkg::CMD_MANUAL_BIT];
                end
                ptp_pkg::ADDR_PWM_PER: begin
                    s_d.pwm_per = hwdata[PWM_W-1:0];
                    s_d.pwm_cnt = '0;
                end
                ptp_pkg::ADDR_PWM_DUTY: begin
                    s_d.pwm_duty = hwdata[PWM_W-1:0];
                end
                default: begin
                    manual = 1'b0;
                end
            endcase
        end

        // Manual trigger starts sequence under manual source
        if (manual && !s_q.seq_ext) begin
            s_d.start_seq = 1'b1;
        end

        // Output trigger pulse
        if (s_q.busy) begin
            if (s_q.pulse_cnt == 16'h0000) begin
                s_d.busy = 1'b0;
            end else begin
                s_d.pulse_cnt = s_q.pulse_cnt - 16'h0001;
            end
        end else if (s_q.mode == ptp_pkg::PTP_MODE_TRIG_OUT && (trig_event || manual)) begin
            s_d.busy      = 1'b1;
            s_d.pulse_cnt = PULSE_LAST;
        end
        if (s_q.mode != ptp_pkg::PTP_MODE_TRIG_OUT) begin
            s_d.busy = 1'b0;
        end

        // PWM generator
        if (s_q.pwm_cnt + PWM_W'(1) >= s_q.pwm_per) begin
            s_d.pwm_cnt = '0;
        end else begin
            s_d.pwm_cnt = s_q.pwm_cnt + PWM_W'(1);
        end
        pwm_lvl = (s_q.pwm_cnt < s_q.pwm_duty);

        // Logical output, then polarity to pin level
        case (s_q.mode)
            ptp_pkg::PTP_MODE_TRIG_OUT: begin
                lout       = s_q.busy;
                s_d.pin_oe = 1'b1;
            end
            ptp_pkg::PTP_MODE_OUTPUT: begin
                lout       = s_q.pwm_en ? pwm_lvl : s_q.out_val;
                s_d.pin_oe = 1'b1;
            end
            default: begin
                lout       = 1'b0;
                s_d.pin_oe = 1'b0;
            end
        endcase
        s_d.pin_o = ~(lout ^ s_q.inv);

        // Bus address phase
        s_d.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_d.wr_pend = hwrite;
            s_d.wr_addr = haddr[7:0];
            if (!hwrite) begin
                s_d.hrdata = read_reg(haddr[7:0], s_q, active_in);
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q           <= '0;
            s_q.sync1     <= 1'b1;
            s_q.sync2     <= 1'b1;
            s_q.mode      <= ptp_pkg::PTP_MODE_TRIG_OUT;
            s_q.tgt       <= ptp_pkg::PTP_TGT_MEAS;
            s_q.pwm_per   <= PWM_W'(ptp_pkg::PWM_PER_RST);
            s_q.pwm_duty  <= PWM_W'(ptp_pkg::PWM_DUTY_RST);
            s_q.hreadyout <= 1'b1;
            s_q.pin_o     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata     = s_q.hrdata;
    assign hreadyout  = s_q.hreadyout;
    assign hresp      = s_q.hresp;
    assign pin_o      = s_q.pin_o;
    assign pin_oe     = s_q.pin_oe;
    assign start_meas = s_q.start_meas;
    assign start_dlog = s_q.start_dlog;
    assign start_seq  = s_q.start_seq;

endmodule : ptp_trig_pin

// ==== ptp_trig_pin_sva.sv ====
// Checker for the trigger pin block: bus answer, pin drive, start pulses.
// Assumes one hclk domain; the control word is snooped off the bus.
`timescale 1ns/1ps
module ptp_trig_pin_sva (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        trig_event,
    input wire logic        pin_i,
    input wire logic        pin_o,
    input wire logic        pin_oe,
    input wire logic        start_meas,
    input wire logic        start_dlog,
    input wire logic        start_seq
);
    localparam int MIN_LOW = ptp_pkg::TRIG_LOW_CYC;
    // ====
    // Shadow of control word and run counters
    logic [31:0] ctrl_q;
    logic [7:0]  wa_q;
    logic        wp_q;
    logic        pa_q;
    logic [3:0]  age_q;
    logic [2:0]  quiet_q;
    logic [10:0] low_q;
    logic [10:0] run_q;
    wire logic       inv       = ctrl_q[0];
    wire logic [1:0] mode      = ctrl_q[2:1];
    wire logic [1:0] tgt       = ctrl_q[4:3];
    wire logic       act       = (pin_i == inv);
    wire logic       trout     = (age_q > 4'h2) && (mode == 2'h0);
    wire logic       any_start = start_meas | start_dlog | start_seq;
    wire logic       ctrl_wr   = wp_q && (wa_q == ptp_pkg::ADDR_CTRL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= 32'h0;
            wa_q    <= 8'h0;
            wp_q    <= 1'b0;
            pa_q    <= 1'b0;
            age_q   <= 4'h0;
            quiet_q <= 3'h0;
            low_q   <= 11'h0;
            run_q   <= 11'h0;
        end else begin
            wp_q    <= hsel && hready && htrans[1] && hwrite;
            wa_q    <= haddr[7:0];
            ctrl_q  <= ctrl_wr ? hwdata : ctrl_q;
            age_q   <= ctrl_wr ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
            quiet_q <= (trig_event || pin_o == inv) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
            low_q   <= (pin_o == inv) ? low_q + {10'h0, low_q != 11'h7ff} : 11'h0;
            pa_q    <= act;
            run_q   <= !act ? run_q : (pa_q ? run_q + {10'h0, run_q != 11'h7ff} : 11'h1);
        end
    end

    // ====
    // Properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_out_active;
        (pin_o == inv)[*2];
    endsequence
    sequence s_no_start;
        !any_start[*8];
    endsequence

    a_bus_zero_okay: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait okay");
    a_trig_out_pulse: assert property (trig_event && trout && quiet_q > 3'h3 |-> ##2 s_out_active)
        else $error("trigger did not start output pulse");
    a_out_pulse_width: assert property (trout && $past(pin_o) == inv && pin_o != inv |->
        low_q >= MIN_LOW && low_q <= MIN_LOW + 4) else $error("output pulse width wrong");
    a_out_level_map: assert property (age_q > 4'h2 && mode == 2'h3 && !ctrl_q[6] |->
        pin_oe && pin_o == !(ctrl_q[5] ^ inv)) else $error("output level wrong");
    a_in_pin_released: assert property (age_q > 4'h2 && (mode == 2'h1 || mode == 2'h2) |-> !pin_oe)
        else $error("pin driven in input role");
    a_start_one_target: assert property ($onehot0({start_meas, start_dlog, start_seq}))
        else $error("more than one start");
    a_start_single: assert property (any_start |=> s_no_start) else $error("start repeated");
    a_meas_cause: assert property (start_meas |-> mode == 2'h1 && tgt == 2'h0 && ctrl_q[8]
        && run_q >= MIN_LOW) else $error("measurement start without cause");
    a_dlog_cause: assert property (start_dlog |-> mode == 2'h1 && tgt == 2'h1 && run_q >= MIN_LOW)
        else $error("recording start without cause");
    a_seq_external: assert property (start_seq && ctrl_q[7] |-> mode == 2'h1 && tgt == 2'h2
        && run_q >= MIN_LOW) else $error("sequence start without cause");
    a_seq_manual: assert property (wp_q && wa_q == ptp_pkg::ADDR_CMD && hwdata[0] && !ctrl_q[7]
        |-> ##[1:2] start_seq) else $error("manual trigger lost");
endmodule : ptp_trig_pin_sva

bind ptp_trig_pin ptp_trig_pin_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .trig_event(trig_event), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .start_meas(start_meas), .start_dlog(start_dlog), .start_seq(start_seq));

// ==== ptp_ext_inst.sv ====
// External trigger instrument on the pin: sends pulses, counts output pulses.
// Assumes a pull-up on the line and the bench clock for pacing.
`timescale 1ns/1ps
module ptp_ext_inst (
    input  wire logic hclk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_i
);
    logic drv_en  = 1'b0;
    logic drv_val = 1'b1;
    logic act_lvl = 1'b0;
    logic prev_q  = 1'b0;
    int   n_act   = 0;
    int   n_pulse = 0;
    // Pull-up when released; contention shows as unknown
    assign pin_i = (pin_oe && drv_en) ? 1'bx : pin_oe ? pin_o : drv_en ? drv_val : 1'b1;
    always @(posedge hclk) begin
        if (pin_oe && pin_o == act_lvl) n_act <= n_act + 1;
        if (pin_oe && pin_o == act_lvl && !prev_q) n_pulse <= n_pulse + 1;
        prev_q <= pin_oe && pin_o == act_lvl;
    end
    task automatic pulse(input logic lvl, input int n);
        @(posedge hclk);
        drv_val <= lvl;
        drv_en  <= 1'b1;
        repeat (n) @(posedge hclk);
        drv_en  <= 1'b0;
    endtask : pulse
endmodule : ptp_ext_inst

// ==== tb_top.sv ====
// Bench for the trigger pin block: bus access, trigger in/out, output modes.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, trig_event = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    wire logic [31:0] hrdata;
    wire logic   hreadyout, hresp, pin_i, pin_o, pin_oe, start_meas, start_dlog, start_seq;
    int n_fail = 0, samples_checked = 0, cyc = 0, n_m = 0, n_d = 0, n_s = 0, np, na, m0, d0, s0;
    logic [8:0] tc[8] = '{9'h102, 9'h002, 9'h00a, 9'h00a, 9'h092, 9'h012, 9'h00a, 9'h01a};
    int         tl[8] = '{620, 620, 620, 599, 620, 620, 600, 620};
    logic [2:0] te[8] = '{3'b100, 3'b000, 3'b010, 3'b000, 3'b001, 3'b000, 3'b010, 3'b000};

    always #25 hclk = ~hclk;
    ptp_trig_pin u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trig_event(trig_event), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .start_meas(start_meas), .start_dlog(start_dlog), .start_seq(start_seq));
    ptp_ext_inst u_ext (.hclk(hclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run

    always @(posedge hclk) begin
        cyc++;
        if (start_meas === 1'b1) n_m++;
        if (start_dlog === 1'b1) n_d++;
        if (start_seq === 1'b1) n_s++;
        if (cyc == 40000) begin
            n_fail++;
            complete_run();
        end
    end

    // ====
    // Bus cycles
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk
    task automatic trig;
        trig_event <= 1'b1;
        @(posedge hclk);
        trig_event <= 1'b0;
    endtask : trig

    // ====
    // Tests
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        `CHK({pin_oe, pin_o}, 2'b11)
        rchk(ptp_pkg::ADDR_CTRL, 32'h0);
        rchk(ptp_pkg::ADDR_PWM_PER, {16'h0, ptp_pkg::PWM_PER_RST});
        rchk(ptp_pkg::ADDR_PWM_DUTY, {16'h0, ptp_pkg::PWM_DUTY_RST});
        wr(8'h20, 32'hffff_ffff);
        rchk(8'h20, 32'h0);
        rchk(ptp_pkg::ADDR_CMD, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            wr(ptp_pkg::ADDR_CTRL, 32'(i));
            u_ext.act_lvl <= i[0];
            repeat (8) @(posedge hclk);
            np = u_ext.n_pulse;
            na = u_ext.n_act;
            trig();
            repeat (100) @(posedge hclk);
            trig();
            rchk(ptp_pkg::ADDR_STATUS, 32'h6 | 32'(i));
            repeat (700) @(posedge hclk);
            `CHK(u_ext.n_pulse - np, 1)
            `CHK(u_ext.n_act - na >= ptp_pkg::TRIG_LOW_CYC, 1'b1)
        end
        $display("test trigger out done");
        wr(ptp_pkg::ADDR_CTRL, 32'h0);
        u_ext.act_lvl <= 1'b0;
        repeat (8) @(posedge hclk);
        np = u_ext.n_pulse;
        s0 = n_s;
        wr(ptp_pkg::ADDR_CMD, 32'h1);
        repeat (700) @(posedge hclk);
        `CHK(n_s - s0, 1)
        `CHK(u_ext.n_pulse - np, 1)
        $display("test manual done");
        for (int k = 0; k < 8; k++) begin
            wr(ptp_pkg::ADDR_CTRL, {23'h0, tc[k]});
            repeat (4) @(posedge hclk);
            m0 = n_m;
            d0 = n_d;
            s0 = n_s;
            u_ext.pulse(1'b0, tl[k]);
            repeat (30) @(posedge hclk);
            `CHK({n_m - m0 == 1, n_d - d0 == 1, n_s - s0 == 1}, te[k])
        end
        wr(ptp_pkg::ADDR_CTRL, 32'h4);
        fork
            u_ext.pulse(1'b0, 40);
            begin
                repeat (20) @(posedge hclk);
                rchk(ptp_pkg::ADDR_STATUS, 32'h2);
            end
        join
        $display("test trigger in done");
        for (int i = 0; i < 4; i++) begin
            wr(ptp_pkg::ADDR_CTRL, {26'h0, i[1], 4'h3, i[0]});
            repeat (4) @(posedge hclk);
            `CHK({pin_oe, pin_o}, {1'b1, !(i[1] ^ i[0])})
        end
        wr(ptp_pkg::ADDR_PWM_PER, 32'ha);
        wr(ptp_pkg::ADDR_PWM_DUTY, 32'h3);
        wr(ptp_pkg::ADDR_CTRL, 32'h46);
        repeat (20) @(posedge hclk);
        na = u_ext.n_act;
        repeat (100) @(posedge hclk);
        `CHK(u_ext.n_act - na, 30)
        $display("test output done");
        complete_run();
    end
endmodule : tb_top
